// File: verilog/efkp_regs.vh
`ifndef EFKP_REGS_VH
`define EFKP_REGS_VH
// ==================================================
// Register word addresses (32-bit words)
`define EFKP_ADDR_W        8
`define EFKP_OFS_KEY       8'h00
`define EFKP_OFS_DIGEST    8'h08
`define EFKP_OFS_USER      8'h14
`define EFKP_OFS_WIDE      8'h15
`define EFKP_OFS_SEC       8'h19
`define EFKP_OFS_CTRL      8'h1A
`define EFKP_OFS_STATUS    8'h1B
`define EFKP_OFS_KEY_CRC   8'h1C
// ==================================================
// Word counts per field
`define EFKP_KEY_WORDS     8
`define EFKP_DIGEST_WORDS  12
`define EFKP_WIDE_WORDS    4
// ==================================================
// Control word bit positions
`define EFKP_CTL_WIDTH     21
`define EFKP_CTL_KEY_CHK   0
`define EFKP_CTL_USER_ACC  1
`define EFKP_CTL_SEC_ACC   2
`define EFKP_CTL_DIG_ACC   6
`define EFKP_CTL_KEY_PRG   7
`define EFKP_CTL_USER_PRG  8
`define EFKP_CTL_SEC_PRG   9
`define EFKP_CTL_DIG_PRG   15
`define EFKP_CTL_WIDE_PRG  16
`define EFKP_CTL_LOCK      20
// ==================================================
// Status bits and reset values
`define EFKP_ST_REFUSED    0
`define EFKP_ST_KEY_OK     1
`define EFKP_SEC_WIDTH     8
`define EFKP_FUSE_RESET    32'h00000000
`endif

// File: verilog/efkp_fuse_word.v
`timescale 1ns/100ps
// ==================================================
// One 32-bit fuse word: programming only takes bits from 0 to 1; nrst clears the word to 0
module efkp_fuse_word
(
  clock,
  nrst,
  program_en,
  program_data,
  fuse_value
);
  input         clock;
  input         nrst;
  input         program_en;
  input  [31:0] program_data;
  output [31:0] fuse_value;

  reg    [31:0] fuse_value;

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      fuse_value <= 32'h00000000;
    else if (program_en)
      fuse_value <= fuse_value | program_data;
  end
endmodule

// File: verilog/efkp_fuse_bank.v
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`include "efkp_regs.vh"
// What this block does
// - User words: each bit set once; zero bits stay programmable later.
// - Holds a 256-bit fused key for bitstream decryption.
// - Holds a 384-bit fused digest for bitstream authentication.
// - Control bit 0 disables key CRC check and key programming.
// - Control bit 1 refuses reading and programming of the 32-bit user word.
// - Control bit 2 refuses reading and programming of the security word.
// - Control bit 6 refuses reading and programming of the digest.
// - Control bit 7 refuses programming of the key.
// - Control bit 8 refuses programming of the 32-bit user word.
// - Control bit 9 refuses programming of the security word.
// - Control bit 15 refuses programming of the digest.
// - Control bit 16 refuses programming of the 128-bit user word.
// - Control bit 20 set blocks programming of other control bits.
module efkp_fuse_bank
(
  clock,
  nrst,
  address,
  write_data,
  write_strobe,
  read_strobe,
  read_data,
  decrypt_key,
  auth_digest,
  key_check_enable,
  security_word
);
  input                       clock;
  input                       nrst;
  input  [`EFKP_ADDR_W-1:0]   address;
  input  [31:0]               write_data;
  input                       write_strobe;
  input                       read_strobe;
  output [31:0]               read_data;
  output [255:0]              decrypt_key;
  output [383:0]              auth_digest;
  output                      key_check_enable;
  output [`EFKP_SEC_WIDTH-1:0] security_word;

  reg    [31:0]               read_data;
  reg    [`EFKP_CTL_WIDTH-1:0] fuse_protect_control;
  reg    [`EFKP_SEC_WIDTH-1:0] security_word_fuses;
  reg                         refused;
  reg    [31:0]               next_read;
  reg                         next_refused;

  wire   [31:0]               key_word    [0:`EFKP_KEY_WORDS-1];
  wire   [31:0]               digest_word [0:`EFKP_DIGEST_WORDS-1];
  wire   [31:0]               wide_word   [0:`EFKP_WIDE_WORDS-1];
  wire   [31:0]               user_word_fuses;
  wire   [127:0]              user_wide_fuses;
  reg    [1:0]                crc_state;
  reg    [1:0]                next_crc_state;
  reg    [2:0]                crc_idx;
  reg    [2:0]                next_crc_idx;
  reg    [31:0]               crc_acc;
  reg    [31:0]               next_crc_acc;
  reg    [31:0]               key_crc;
  reg    [31:0]               next_key_crc;

  // ==================================================
  // Protection decode
  wire key_check_program_block     = fuse_protect_control[`EFKP_CTL_KEY_CHK];
  wire user_word_access_block      = fuse_protect_control[`EFKP_CTL_USER_ACC];
  wire security_word_access_block  = fuse_protect_control[`EFKP_CTL_SEC_ACC];
  wire digest_access_block         = fuse_protect_control[`EFKP_CTL_DIG_ACC];
  wire key_program_block           = fuse_protect_control[`EFKP_CTL_KEY_PRG];
  wire user_word_program_block     = fuse_protect_control[`EFKP_CTL_USER_PRG];
  wire security_word_program_block = fuse_protect_control[`EFKP_CTL_SEC_PRG];
  wire digest_program_block        = fuse_protect_control[`EFKP_CTL_DIG_PRG];
  wire wide_user_program_block     = fuse_protect_control[`EFKP_CTL_WIDE_PRG];
  wire control_word_lock           = fuse_protect_control[`EFKP_CTL_LOCK];

  wire key_wr_ok  = !key_check_program_block
                    && !key_program_block;
  wire user_wr_ok = !user_word_access_block
                    && !user_word_program_block;
  wire sec_wr_ok  = !security_word_access_block
                    && !security_word_program_block;
  wire dig_wr_ok  = !digest_access_block
                    && !digest_program_block;
  wire wide_wr_ok = !wide_user_program_block;

  // ==================================================
  // Address decode
  wire in_key  = (address < `EFKP_OFS_KEY + `EFKP_KEY_WORDS);
  wire in_dig  = (address >= `EFKP_OFS_DIGEST) &&
                 (address < `EFKP_OFS_DIGEST + `EFKP_DIGEST_WORDS);
  wire in_wide = (address >= `EFKP_OFS_WIDE) &&
                 (address < `EFKP_OFS_WIDE + `EFKP_WIDE_WORDS);
  wire [`EFKP_ADDR_W-1:0] key_idx  = address - `EFKP_OFS_KEY;
  wire [`EFKP_ADDR_W-1:0] dig_idx  = address - `EFKP_OFS_DIGEST;
  wire [`EFKP_ADDR_W-1:0] wide_idx = address - `EFKP_OFS_WIDE;

  wire user_hit = address == `EFKP_OFS_USER;
  wire sec_hit  = address == `EFKP_OFS_SEC;
  wire ctl_hit  = address == `EFKP_OFS_CTRL;

  wire wr_refuse = write_strobe &&
                   ((in_key && !key_wr_ok) || (in_dig && !dig_wr_ok) ||
                    (user_hit && !user_wr_ok) || (sec_hit && !sec_wr_ok) ||
                    (in_wide && !wide_wr_ok));

  // ==================================================
  // Fuse storage
  genvar gi;
  generate
    for (gi = 0; gi < `EFKP_KEY_WORDS; gi = gi + 1)
    begin : g_key
      efkp_fuse_word u_word
      (
        .clock        (clock),
        .nrst         (nrst),
        .program_en   (write_strobe && in_key && key_idx == gi
                       && key_wr_ok),
        .program_data (write_data),
        .fuse_value   (key_word[gi])
      );
      assign decrypt_key[gi*32 +: 32] = key_word[gi];
    end
    for (gi = 0; gi < `EFKP_DIGEST_WORDS; gi = gi + 1)
    begin : g_dig
      efkp_fuse_word u_word
      (
        .clock        (clock),
        .nrst         (nrst),
        .program_en   (write_strobe && in_dig && dig_idx == gi
                       && dig_wr_ok),
        .program_data (write_data),
        .fuse_value   (digest_word[gi])
      );
      assign auth_digest[gi*32 +: 32] = digest_word[gi];
    end
    for (gi = 0; gi < `EFKP_WIDE_WORDS; gi = gi + 1)
    begin : g_wide
      efkp_fuse_word u_word
      (
        .clock        (clock),
        .nrst         (nrst),
        .program_en   (write_strobe && in_wide && wide_idx == gi
                       && wide_wr_ok),
        .program_data (write_data),
        .fuse_value   (wide_word[gi])
      );
      assign user_wide_fuses[gi*32 +: 32] = wide_word[gi];
    end
  endgenerate

  efkp_fuse_word u_user
  (
    .clock        (clock),
    .nrst         (nrst),
    .program_en   (write_strobe && user_hit && user_wr_ok),
    .program_data (write_data),
    .fuse_value   (user_word_fuses)
  );

  // ==================================================
  // Control and security words
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      fuse_protect_control <= {`EFKP_CTL_WIDTH{1'b0}};
      security_word_fuses  <= {`EFKP_SEC_WIDTH{1'b0}};
    end
    else if (write_strobe)
    begin
      if (ctl_hit)
      begin
        // Lock bit itself stays settable; others frozen once locked
        if (control_word_lock)
          fuse_protect_control[`EFKP_CTL_LOCK] <= 1'b1;
        else
          fuse_protect_control <= fuse_protect_control
                                  | write_data[`EFKP_CTL_WIDTH-1:0];
      end
      if (sec_hit && sec_wr_ok)
        security_word_fuses <= security_word_fuses
                               | write_data[`EFKP_SEC_WIDTH-1:0];
    end
  end

  // ==================================================
  // Key integrity: CRC over the key words, one word per clock
  // The walk restarts on each accepted key write, so the value
  // matches the fuses whenever the engine is back at idle
  localparam [1:0]  CRC_IDLE = 2'b00;
  localparam [1:0]  CRC_RUN  = 2'b01;
  localparam [1:0]  CRC_DONE = 2'b10;
  // Generator is a plain default; any 32-bit polynomial would serve
  localparam [31:0] CRC_POLY = 32'h04C11DB7;

  wire key_write = write_strobe && in_key && key_wr_ok;
  wire crc_idle  = crc_state == CRC_IDLE;

  // One word through the CRC, most significant bit first
  function [31:0] crc_word;
    input [31:0] crc_in;
    input [31:0] data;
    integer      b;
    reg   [31:0] c;
    begin
      c = crc_in;
      for (b = 31; b >= 0; b = b - 1)
      begin
        if (c[31] ^ data[b])
          c = {c[30:0], 1'b0} ^ CRC_POLY;
        else
          c = {c[30:0], 1'b0};
      end
      crc_word = c;
    end
  endfunction

  always @*
  begin
    next_crc_state = crc_state;
    next_crc_idx   = crc_idx;
    next_crc_acc   = crc_acc;
    next_key_crc   = key_crc;
    case (crc_state)
      CRC_IDLE:
      begin
        next_crc_idx = 3'd0;
      end
      CRC_RUN:
      begin
        next_crc_acc = crc_word(crc_acc, key_word[crc_idx]);
        next_crc_idx = crc_idx + 3'd1;
        if (crc_idx == `EFKP_KEY_WORDS - 1)
          next_crc_state = CRC_DONE;
      end
      CRC_DONE:
      begin
        next_key_crc   = crc_acc;
        next_crc_state = CRC_IDLE;
      end
      default:
      begin
        next_crc_state = CRC_IDLE;
      end
    endcase
    // A key write in mid-walk starts over so no stale word is folded in
    if (key_write)
    begin
      next_crc_state = CRC_RUN;
      next_crc_idx   = 3'd0;
      next_crc_acc   = 32'h00000000;
    end
  end

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      crc_state <= CRC_RUN;
      crc_idx   <= 3'd0;
      crc_acc   <= 32'h00000000;
      key_crc   <= 32'h00000000;
    end
    else
    begin
      crc_state <= next_crc_state;
      crc_idx   <= next_crc_idx;
      crc_acc   <= next_crc_acc;
      key_crc   <= next_key_crc;
    end
  end

  assign key_check_enable = !key_check_program_block;
  assign security_word    = security_word_fuses;

  // ==================================================
  // Read path and sticky refusal flag
  always @*
  begin
    next_read    = 32'h00000000;
    next_refused = refused;
    if (read_strobe)
    begin
      if (in_key)
        next_refused = 1'b1;
      else if (in_dig)
      begin
        if (digest_access_block)
          next_refused = 1'b1;
        else
          next_read = digest_word[dig_idx[3:0]];
      end
      else if (user_hit)
      begin
        if (user_word_access_block)
          next_refused = 1'b1;
        else
          next_read = user_word_fuses;
      end
      else if (in_wide)
        next_read = wide_word[wide_idx[1:0]];
      else if (sec_hit)
      begin
        if (security_word_access_block)
          next_refused = 1'b1;
        else
          next_read = {{(32-`EFKP_SEC_WIDTH){1'b0}}, security_word_fuses};
      end
      else if (ctl_hit)
        next_read = {{(32-`EFKP_CTL_WIDTH){1'b0}}, fuse_protect_control};
      else if (address == `EFKP_OFS_STATUS)
      begin
        next_read = {30'h00000000,
                     key_check_enable && crc_idle
                     && key_crc != 32'h00000000,
                     refused};
        next_refused = 1'b0;
      end
      else if (address == `EFKP_OFS_KEY_CRC)
      begin
        if (key_check_program_block)
          next_read = 32'h00000000;
        else
          next_read = key_crc;
      end
    end
    if (wr_refuse || (write_strobe && ctl_hit && control_word_lock))
      next_refused = 1'b1;
  end

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      read_data <= 32'h00000000;
      refused   <= 1'b0;
    end
    else
    begin
      read_data <= next_read;
      refused   <= next_refused;
    end
  end
endmodule

// File: bench/efkp_props.sv
`timescale 1ns/100ps
`include "efkp_regs.vh"
// ==================================================
// Checker on the fuse bank ports
module efkp_props
(
  input wire                     clock,
  input wire                     nrst,
  input wire [`EFKP_ADDR_W-1:0]  address,
  input wire [31:0]              write_data,
  input wire                     write_strobe,
  input wire                     read_strobe,
  input wire [31:0]              read_data,
  input wire [255:0]             decrypt_key,
  input wire [383:0]             auth_digest,
  input wire                     key_check_enable,
  input wire [`EFKP_SEC_WIDTH-1:0] security_word
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  idle_read_zero_a: assert property (
    !$past(read_strobe) |-> read_data == 32'h0) else $error("data w/o read");
  key_read_zero_a: assert property (
    read_strobe && address < `EFKP_OFS_DIGEST |=> read_data == 32'h0)
    else $error("key word read out");
  key_only_sets_a: assert property (
    ($past(decrypt_key) & ~decrypt_key) == 256'h0) else $error("key cleared");
  digest_only_sets_a: assert property (
    ($past(auth_digest) & ~auth_digest) == 384'h0) else $error("digest clr");
  sec_only_sets_a: assert property (
    ($past(security_word) & ~security_word) == 8'h0) else $error("sec clr");
  check_off_sticks_a: assert property (
    !$past(key_check_enable) |-> !key_check_enable) else $error("chk back");
  key_frozen_a: assert property (
    !key_check_enable |=> $stable(decrypt_key)) else $error("key changed");
  digest_quiet_a: assert property (
    !write_strobe |=> $stable(auth_digest)) else $error("digest moved");
endmodule

// File: bench/efkp_prog.sv
`timescale 1ns/100ps
// ==================================================
// Programmer model: one-cycle strobes, lines inverted when released
module efkp_prog
(
  input wire         clock,
  input wire  [31:0] read_data,
  output reg  [7:0]  address,
  output reg  [31:0] write_data,
  output reg         write_strobe,
  output reg         read_strobe
);
  initial
  begin
    address = 8'h00;
    write_data = 32'h0;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
  end
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge clock);
      address <= a;
      write_data <= v;
      write_strobe <= 1'b1;
      @(posedge clock);
      write_strobe <= 1'b0;
      address <= ~a;
      write_data <= ~v;
      @(negedge clock);
    end
  endtask
  task rd(input [7:0] a, output [31:0] v);
    begin
      @(posedge clock);
      address <= a;
      read_strobe <= 1'b1;
      @(posedge clock);
      read_strobe <= 1'b0;
      address <= ~a;
      @(negedge clock);
      v = read_data;
    end
  endtask
endmodule

// File: bench/testbench.sv
`timescale 1ns/100ps
module testbench;
  reg          clock;
  reg          nrst;
  wire [7:0]   address;
  wire [31:0]  write_data;
  wire         write_strobe;
  wire         read_strobe;
  wire [31:0]  read_data;
  wire [255:0] decrypt_key;
  wire [383:0] auth_digest;
  wire         key_check_enable;
  wire [7:0]   security_word;
  reg  [31:0]  d;
  integer      n_fail;
  integer      comparisons;
  integer      i;
  localparam [39:0] BITS = {8'd16, 8'd8, 8'd9, 8'd15, 8'd7};
  localparam [39:0] ADRS = {8'h15, 8'h14, 8'h19, 8'h08, 8'h00};
  efkp_fuse_bank u_dut (.clock(clock), .nrst(nrst), .address(address),
    .write_data(write_data), .write_strobe(write_strobe),
    .read_strobe(read_strobe), .read_data(read_data),
    .decrypt_key(decrypt_key), .auth_digest(auth_digest),
    .key_check_enable(key_check_enable), .security_word(security_word));
  efkp_prog u_prog (.clock(clock), .read_data(read_data),
    .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp)
      begin
        n_fail = n_fail + 1;
        $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task rchk(input [7:0] a, input [31:0] exp);
    begin
      u_prog.rd(a, d);
      chk(d, exp);
    end
  endtask
  task results;
    begin
      $display("fails %0d of %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial
  begin
    #400000;
    n_fail = n_fail + 1;
    results;
  end
  initial
  begin
    n_fail = 0;
    comparisons = 0;
    nrst = 1'b0;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    u_prog.wr(8'h14, 32'h1);
    rchk(8'h14, 32'h1);
    u_prog.wr(8'h14, 32'h2);
    u_prog.wr(8'h14, 32'h0);
    rchk(8'h14, 32'h3);
    u_prog.wr(8'h15, 32'hF0);
    u_prog.wr(8'h00, 32'hA5);
    u_prog.wr(8'h13, 32'hC3);
    u_prog.wr(8'h19, 32'h5A);
    chk(decrypt_key[31:0], 32'hA5);
    chk(auth_digest[383:352], 32'hC3);
    chk({24'h0, security_word}, 32'h5A);
    rchk(8'h00, 32'h0);
    rchk(8'hFF, 32'h0);
    for (i = 0; i < 5; i = i + 1)
    begin
      u_prog.wr(8'h1A, 32'h1 << BITS[8*i +: 8]);
      u_prog.rd(8'h1B, d);
      u_prog.wr(ADRS[8*i +: 8], 32'hFFFFFFFF);
      u_prog.rd(8'h1B, d);
      chk(d & 32'h1, 32'h1);
    end
    rchk(8'h15, 32'hF0);
    rchk(8'h14, 32'h3);
    chk({24'h0, security_word}, 32'h5A);
    chk(auth_digest[31:0], 32'h0);
    chk(decrypt_key[31:0], 32'hA5);
    u_prog.wr(8'h1A, 32'h1);
    chk({31'h0, key_check_enable}, 32'h0);
    rchk(8'h1C, 32'h0);
    u_prog.wr(8'h1A, 32'h46);
    rchk(8'h14, 32'h0);
    rchk(8'h19, 32'h0);
    rchk(8'h13, 32'h0);
    u_prog.wr(8'h1A, 32'h100000);
    u_prog.wr(8'h1A, 32'h8);
    rchk(8'h1A, 32'h1183C7);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    u_prog.wr(8'h1A, 32'h1);
    u_prog.wr(8'h00, 32'hFF);
    chk(decrypt_key[31:0], 32'h0);
    rchk(8'h1A, 32'h1);
    results;
  end
endmodule
bind efkp_fuse_bank efkp_props u_props (.clock(clock), .nrst(nrst),
  .address(address), .write_data(write_data),
  .write_strobe(write_strobe), .read_strobe(read_strobe),
  .read_data(read_data), .decrypt_key(decrypt_key),
  .auth_digest(auth_digest), .key_check_enable(key_check_enable),
  .security_word(security_word));
